// file: logic/rec_pkg.sv
package rec_pkg;
  // Cell array geometry
  localparam int ROWS = 128;
  localparam int COLS = 4;
  localparam int ROW_W = 7;
  localparam int PARAM_ROWS = 64;

  // Parameter bit positions within the voted vector
  localparam int FAULT_LVL_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int DRIVE_LSB = 2;
  localparam int RANGE_LSB = 4;
  localparam int FINE_LSB = 7;
  localparam int CURV_LSB = 15;
  localparam int PARITY_BIT = 63;
  localparam logic [1:0] DRIVE_FACTORY = 2'h1;

  // Spare rows, all four cells raw
  localparam int ID_ROW_FIRST = 64;
  localparam int SERIAL_ROW_FIRST = 80;
  localparam int LUT_ROW_FIRST = 86;
  localparam int CRC_ROW_FIRST = 120;

  // Serial frame: command, row, data, first bit first
  localparam int FRAME_BITS = 13;
  localparam logic [3:0] FRAME_LAST = 4'hc;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int WRITE_TIME_NS = 10000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_BIT_NS = 500;
  localparam int READ_BIT_CYCLES = (READ_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] WRITE_LAST = 12'(WRITE_CYCLES - 1);
  localparam logic [11:0] READ_BIT_LAST = 12'(READ_BIT_CYCLES - 1);

  // Register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_SESSION = 8'h0c;
  localparam logic [7:0] REG_ARRAY_SEL = 8'h10;
  localparam logic [7:0] REG_ARRAY_DATA = 8'h14;

  // Event bits of status and mask
  localparam int EV_PARITY = 0;
  localparam int EV_LOCK_REFUSED = 1;
  localparam int EV_WRITE_DONE = 2;
  localparam int EV_READ_DONE = 3;
  localparam int EV_CELL_MISMATCH = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_LISTEN = 4'h2,
    ST_WRITE = 4'h4,
    ST_READ = 4'h8
  } rec_state_t;

  // Factory image: drive field at 1, parity kept even
  function automatic logic [ROWS-1:0][COLS-1:0] rec_factory();
    logic [ROWS-1:0][COLS-1:0] img;
    img = '0;
    img[DRIVE_LSB] = 4'h7;
    img[PARITY_BIT] = 4'h7;
    return img;
  endfunction

  localparam logic [ROWS-1:0][COLS-1:0] FACTORY_IMAGE = rec_factory();
endpackage

// file: logic/rec_vote3.sv
`timescale 1ns/1ps
module rec_vote3 #(
  parameter int W = 64
) (
  input wire logic [W-1:0] copy_a_in,
  input wire logic [W-1:0] copy_b_in,
  input wire logic [W-1:0] copy_c_in,
  output logic [W-1:0] vote_out,
  output logic [W-1:0] mismatch_out
);
  // Two of three decide; one flipped cell is outvoted
  assign vote_out = (copy_a_in & copy_b_in) | (copy_a_in & copy_c_in) | (copy_b_in & copy_c_in);
  assign mismatch_out = (copy_a_in ^ copy_b_in) | (copy_a_in ^ copy_c_in);
endmodule

// file: logic/rec_config_store.sv
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Function
// - Parity error drives output to diagnostic low or high per fault level select.
// - Each parameter bit held in three cells, value by majority vote.
// - A flip of two or all three cells corrupts a bit; parity guard then forces diagnostic level.
// - Array is four columns by 128 rows; copies of a bit share a row.
// - Customer serial bits are stored raw, without copies or voting.
// - Spare cells never influence operating behaviour.
// - Spare cells hold CRC bits guarding factory ID and lookup data.
// - Two-bit output drive field sets amplifier current, factory value 1.
// - Lock bit set at session entry opens program mode read-only and blocks every memory change.
// - Raised programming supply puts the device into program mode.
// - Serial data arrive tri-level self-clocked on output pin, sampled at bit start.
// - Read command answered by modulating supply current with memory contents.
// - Each die holds a factory ID plus user serial storage.
// - Three drift fields set compensation; lookup table kept readable.
// - Memory stays readable whether or not locked.
module rec_config_store (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic prog_supply_high_in,
  input wire logic [1:0] pin_level_in,
  input wire logic [rec_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output logic diag_active_out,
  output logic diag_high_out,
  output logic fault_level_select_out,
  output logic memory_lock_bit_out,
  output logic [1:0] output_drive_out,
  output logic [2:0] drift_range_select_out,
  output logic [7:0] drift_fine_adjust_out,
  output logic [3:0] drift_curvature_adjust_out,
  output logic prog_mode_out,
  output logic supply_current_mod_out
);
  import rec_pkg::*;

  typedef struct packed {
    logic [ROWS-1:0][COLS-1:0] cells;
    rec_state_t state;
    logic prog_mode;
    logic read_only;
    logic [1:0] lvl_prev;
    logic [3:0] bit_cnt;
    logic [FRAME_BITS-1:0] shreg;
    logic [11:0] cnt;
    logic [ROW_W-1:0] row;
    logic [COLS-1:0] data;
    logic [1:0] rd_bits;
    logic cur_mod;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [ROW_W-1:0] array_sel;
    logic [31:0] rdata;
    logic irq;
    logic diag_active;
    logic diag_high;
    logic fault_lvl;
    logic lock;
    logic [1:0] drive;
    logic [2:0] range;
    logic [7:0] fine;
    logic [3:0] curv;
  } rec_q_t;

  rec_q_t q;
  rec_q_t d;

  logic [PARAM_ROWS-1:0] copy_a;
  logic [PARAM_ROWS-1:0] copy_b;
  logic [PARAM_ROWS-1:0] copy_c;
  logic [PARAM_ROWS-1:0] voted;
  logic [PARAM_ROWS-1:0] mism;
  logic parity_err;
  logic lvl_edge;
  logic [FRAME_BITS-1:0] frame_next;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] w1c;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    return addr == off;
  endfunction

  // Only parameter rows feed the voter; spare rows reach no control path
  for (genvar i = 0; i < PARAM_ROWS; i++) begin : g_copies
    assign copy_a[i] = q.cells[i][0];
    assign copy_b[i] = q.cells[i][1];
    assign copy_c[i] = q.cells[i][2];
  end

  rec_vote3 #(
    .W(PARAM_ROWS)
  ) u_vote (
    .copy_a_in(copy_a),
    .copy_b_in(copy_b),
    .copy_c_in(copy_c),
    .vote_out(voted),
    .mismatch_out(mism)
  );

  // Even parity over all voted parameter bits
  assign parity_err = ^voted;
  // Bit start: line leaves the idle middle level
  assign lvl_edge = q.prog_mode && q.lvl_prev == LVL_MID &&
                    (pin_level_in == LVL_LOW || pin_level_in == LVL_HIGH);
  assign frame_next = {q.shreg[FRAME_BITS-2:0], pin_level_in == LVL_HIGH};

  always_comb begin
    d = q;
    events = '0;
    w1c = '0;
    d.lvl_prev = pin_level_in;
    if (!prog_supply_high_in) begin
      d.state = ST_OFF;
      d.prog_mode = 1'b0;
      d.read_only = 1'b0;
      d.bit_cnt = '0;
      d.cur_mod = 1'b0;
    end else begin
      case (q.state)
        ST_OFF: begin
          // Raised supply seen: session opens, read-only when locked
          d.state = ST_LISTEN;
          d.prog_mode = 1'b1;
          d.read_only = voted[LOCK_BIT];
          d.bit_cnt = '0;
        end
        ST_LISTEN: begin
          if (lvl_edge) begin
            d.shreg = frame_next;
            if (q.bit_cnt == FRAME_LAST) begin
              d.bit_cnt = '0;
              d.row = frame_next[10:4];
              d.cnt = '0;
              if (frame_next[12:11] == CMD_WRITE) begin
                if (q.read_only) begin
                  events[EV_LOCK_REFUSED] = 1'b1;
                end else begin
                  d.data = frame_next[3:0];
                  d.state = ST_WRITE;
                end
              end else if (frame_next[12:11] == CMD_READ) begin
                // Raw cells returned, locked or not
                d.data = q.cells[frame_next[10:4]];
                d.rd_bits = '0;
                d.state = ST_READ;
              end
            end else begin
              d.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end
        ST_WRITE: begin
          if (q.cnt == WRITE_LAST) begin
            d.cells[q.row] = q.data;
            events[EV_WRITE_DONE] = 1'b1;
            d.state = ST_LISTEN;
            d.cnt = '0;
          end else begin
            d.cnt = q.cnt + 12'h001;
          end
        end
        ST_READ: begin
          if (q.cnt == READ_BIT_LAST) begin
            d.cnt = '0;
            if (q.rd_bits == 2'h3) begin
              events[EV_READ_DONE] = 1'b1;
              d.state = ST_LISTEN;
            end else begin
              d.rd_bits = q.rd_bits + 2'h1;
              d.data = {q.data[COLS-2:0], 1'b0};
            end
          end else begin
            d.cnt = q.cnt + 12'h001;
          end
        end
        default: begin
          d.state = ST_OFF;
        end
      endcase
    end
    // Current load follows the bit being returned, MSB first
    d.cur_mod = (d.state == ST_READ) ? d.data[COLS-1] : 1'b0;

    // Voted settings drive the analog path
    d.fault_lvl = voted[FAULT_LVL_BIT];
    d.lock = voted[LOCK_BIT];
    d.drive = voted[DRIVE_LSB +: 2];
    d.range = voted[RANGE_LSB +: 3];
    d.fine = voted[FINE_LSB +: 8];
    d.curv = voted[CURV_LSB +: 4];
    d.diag_active = parity_err;
    d.diag_high = voted[FAULT_LVL_BIT];
    events[EV_PARITY] = parity_err;
    events[EV_CELL_MISMATCH] = |mism;

    if (reg_wr_in) begin
      if (reg_hit(reg_addr_in, REG_STATUS)) begin
        w1c = reg_wdata_in[EV_W-1:0];
      end else if (reg_hit(reg_addr_in, REG_MASK)) begin
        d.mask = reg_wdata_in[EV_W-1:0];
      end else if (reg_hit(reg_addr_in, REG_ARRAY_SEL)) begin
        d.array_sel = reg_wdata_in[ROW_W-1:0];
      end
    end
    // New event wins over a clear in the same cycle
    d.status = (q.status & ~w1c) | events;
    d.irq = |(d.status & d.mask);

    d.rdata = '0;
    if (reg_rd_in) begin
      if (reg_hit(reg_addr_in, REG_STATUS)) begin
        d.rdata = {27'h0, q.status};
      end else if (reg_hit(reg_addr_in, REG_MASK)) begin
        d.rdata = {27'h0, q.mask};
      end else if (reg_hit(reg_addr_in, REG_CONFIG)) begin
        d.rdata = {13'h0, q.curv, q.fine, q.range, q.drive, q.lock, q.fault_lvl};
      end else if (reg_hit(reg_addr_in, REG_SESSION)) begin
        d.rdata = {26'h0, q.state, q.read_only, q.prog_mode};
      end else if (reg_hit(reg_addr_in, REG_ARRAY_SEL)) begin
        d.rdata = {25'h0, q.array_sel};
      end else if (reg_hit(reg_addr_in, REG_ARRAY_DATA)) begin
        // ID, serial, lookup and CRC rows read back unvoted
        d.rdata = {28'h0, q.cells[q.array_sel]};
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.cells <= FACTORY_IMAGE;
      q.state <= ST_OFF;
      q.lvl_prev <= LVL_MID;
      q.status <= STATUS_RST;
      q.mask <= MASK_RST;
      q.drive <= DRIVE_FACTORY;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign irq_out = q.irq;
  assign diag_active_out = q.diag_active;
  assign diag_high_out = q.diag_high;
  assign fault_level_select_out = q.fault_lvl;
  assign memory_lock_bit_out = q.lock;
  assign output_drive_out = q.drive;
  assign drift_range_select_out = q.range;
  assign drift_fine_adjust_out = q.fine;
  assign drift_curvature_adjust_out = q.curv;
  assign prog_mode_out = q.prog_mode;
  assign supply_current_mod_out = q.cur_mod;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_frame_end;
    q.state == ST_LISTEN && lvl_edge && q.bit_cnt == FRAME_LAST && prog_supply_high_in;
  endsequence

  sequence s_locked_write;
    s_frame_end ##0 (q.read_only && frame_next[12:11] == CMD_WRITE);
  endsequence

  sequence s_read_start;
    s_frame_end ##0 (frame_next[12:11] == CMD_READ);
  endsequence

  sequence s_write_end;
    q.state == ST_WRITE && q.cnt == WRITE_LAST && prog_supply_high_in;
  endsequence

  sequence s_read_end;
    q.state == ST_READ && q.cnt == READ_BIT_LAST && q.rd_bits == 2'h3 && prog_supply_high_in;
  endsequence

  sequence s_bit_mid;
    q.state == ST_LISTEN && lvl_edge && q.bit_cnt != FRAME_LAST && prog_supply_high_in;
  endsequence

  AST_DIAG_LEVEL: assert property (
    parity_err |=> diag_active_out && diag_high_out == $past(voted[FAULT_LVL_BIT]))
    else $error("diagnostic level wrong after parity error");
  AST_MAJORITY: assert property (
    (q.cells[FAULT_LVL_BIT][0] == q.cells[FAULT_LVL_BIT][2])
    |=> fault_level_select_out == $past(q.cells[FAULT_LVL_BIT][0]))
    else $error("voted bit disagrees with two matching cells");
  AST_SINGLE_FLIP: assert property (
    (!parity_err && $countones(q.cells[LOCK_BIT][2:0]) == 1) |=> !memory_lock_bit_out)
    else $error("single flipped cell changed a bit");
  AST_LOCK_BLOCK: assert property (
    s_locked_write |=> $stable(q.cells) && q.state == ST_LISTEN && q.status[EV_LOCK_REFUSED])
    else $error("write accepted while locked");
  AST_ENTRY: assert property (
    (q.state == ST_OFF && prog_supply_high_in)
    |=> prog_mode_out && q.read_only == $past(voted[LOCK_BIT]))
    else $error("program mode entry wrong");
  AST_WRITE_COMMIT: assert property (
    s_write_end |=> q.cells[$past(q.row)] == $past(q.data) && q.status[EV_WRITE_DONE])
    else $error("write not committed at end of write time");
  AST_READ_HOLD: assert property (
    s_read_start |=> (q.state == ST_READ && supply_current_mod_out == q.data[COLS-1])[*8])
    else $error("read back not presented on supply current");
  AST_IRQ: assert property (
    (q.status & q.mask) != '0 |-> irq_out)
    else $error("interrupt low with unmasked status");
  AST_W1C_SET_WINS: assert property (
    (reg_wr_in && reg_addr_in == REG_STATUS && parity_err) |=> q.status[EV_PARITY])
    else $error("event lost under clear");
  AST_SUPPLY_DROP: assert property (
    !prog_supply_high_in |=> !prog_mode_out && q.state == ST_OFF && !supply_current_mod_out)
    else $error("session kept after supply drop");
  AST_BIT_SHIFT: assert property (
    s_bit_mid |=> q.bit_cnt == $past(q.bit_cnt) + 4'h1 &&
    q.shreg[0] == ($past(pin_level_in) == LVL_HIGH))
    else $error("frame bit not taken at its leading edge");
  AST_BUSY_IGNORES_BITS: assert property (
    (q.state == ST_WRITE || q.state == ST_READ) |=> $stable(q.bit_cnt))
    else $error("bit counted during write or read back");
  AST_DRIVE_FIELD: assert property (
    1'b1 |=> output_drive_out == $past(voted[DRIVE_LSB +: 2]))
    else $error("drive field does not follow voted cells");
  AST_SPARE_INERT: assert property (
    s_write_end ##0 q.row[ROW_W-1] |=> $stable(voted))
    else $error("spare row write changed a setting");
  AST_READ_DONE: assert property (
    s_read_end |=> q.state == ST_LISTEN && !supply_current_mod_out && q.status[EV_READ_DONE])
    else $error("read back did not end after four bits");
  AST_RDATA_IDLE: assert property (
    !reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data present without a read");
  AST_WRITE_HOLD: assert property (
    (q.state == ST_WRITE && q.cnt != WRITE_LAST && prog_supply_high_in)
    |=> q.state == ST_WRITE && $stable(q.cells))
    else $error("cells changed before the write time ran out");
endmodule

// file: verification/rec_programmer_model.sv
`timescale 1ns/1ps
module rec_programmer_model (
  input wire logic clk_in,
  input wire logic supply_current_mod_in,
  output logic supply_high_out,
  output logic [1:0] level_out
);
  import rec_pkg::*;
  initial begin
    supply_high_out = 1'b0;
    level_out = LVL_MID;
  end
  task automatic supply(input logic on);
    @(posedge clk_in);
    supply_high_out <= on;
    level_out <= LVL_MID;
    repeat (3) @(posedge clk_in);
  endtask
  // Idle mid before every bit, bit level on the next edge
  task automatic send_frame(input logic [1:0] cmd, input logic [6:0] row, input logic [3:0] d);
    logic [12:0] f;
    f = {cmd, row, d};
    for (int i = 12; i >= 0; i--) begin
      @(posedge clk_in);
      level_out <= LVL_MID;
      @(posedge clk_in);
      level_out <= f[i] ? LVL_HIGH : LVL_LOW;
    end
    @(posedge clk_in);
    level_out <= LVL_MID;
  endtask
  task automatic write_row(input logic [6:0] row, input logic [3:0] d);
    send_frame(CMD_WRITE, row, d);
    repeat (2010) @(posedge clk_in);
  endtask
  // Sample each current bit in mid-window
  task automatic read_row(input logic [6:0] row, output logic [3:0] d);
    send_frame(CMD_READ, row, 4'h0);
    repeat (50) @(posedge clk_in);
    for (int i = 3; i >= 0; i--) begin
      #1 d[i] = supply_current_mod_in;
      repeat (100) @(posedge clk_in);
    end
  endtask
endmodule

// file: verification/test_redundant_eeprom_config_store.sv
`timescale 1ns/1ps
module test_redundant_eeprom_config_store;
  import rec_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic prog_supply_high_in;
  logic [1:0] pin_level_in;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic irq_out, diag_active_out, diag_high_out, fault_sel, lock_bit, prog_mode_out, mod;
  logic [1:0] drive;
  logic [2:0] range;
  logic [7:0] fine;
  logic [3:0] curv;
  logic [3:0] cells [ROWS];
  logic [3:0] d4;
  logic [31:0] d;
  logic locked = 1'b0;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  rec_config_store uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .prog_supply_high_in(prog_supply_high_in), .pin_level_in(pin_level_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
    .diag_active_out(diag_active_out), .diag_high_out(diag_high_out),
    .fault_level_select_out(fault_sel), .memory_lock_bit_out(lock_bit),
    .output_drive_out(drive), .drift_range_select_out(range),
    .drift_fine_adjust_out(fine), .drift_curvature_adjust_out(curv),
    .prog_mode_out(prog_mode_out), .supply_current_mod_out(mod));
  rec_programmer_model prg (.clk_in(sys_clk_in), .supply_current_mod_in(mod),
    .supply_high_out(prog_supply_high_in), .level_out(pin_level_in));
  // Reference model: majority vote and even parity
  function automatic logic v(int r);
    return (cells[r][0] & cells[r][1]) | (cells[r][0] & cells[r][2]) | (cells[r][1] & cells[r][2]);
  endfunction
  function automatic logic [31:0] exp_cfg();
    logic [31:0] c;
    c = '0;
    for (int k = 0; k < 19; k++) c[k] = v(k);
    return c;
  endfunction
  function automatic logic perr();
    logic p;
    p = 1'b0;
    for (int k = 0; k < PARAM_ROWS; k++) p ^= v(k);
    return p;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_outs();
    #1;
    chk({12'h0, diag_active_out, curv, fine, range, drive, lock_bit, fault_sel},
      {12'h0, perr(), 19'(exp_cfg())});
    chk({31'h0, diag_high_out}, {31'h0, v(0)});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= x;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 x = reg_rdata_out;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    chk(x, e);
  endtask
  task automatic wrow(input int r, input logic [3:0] x);
    prg.write_row(7'(r), x);
    if (!locked) cells[r] = x;
  endtask
  task automatic rrow(input int r);
    prg.read_row(7'(r), d4);
    chk({28'h0, d4}, {28'h0, cells[r]});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    for (int k = 0; k < ROWS; k++) cells[k] = 4'h0;
    cells[2] = 4'h7;
    cells[63] = 4'h7;
    void'($urandom(73));
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk_outs();
    rd_chk(REG_CONFIG, exp_cfg());
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_SESSION, 32'h4);
    wr(8'h40, 32'hffffffff);
    rd_chk(8'h40, 32'h0);
    d = 32'($urandom_range(31));
    wr(REG_MASK, d);
    rd_chk(REG_MASK, d);
    $display("test reset_and_registers done");
    prg.supply(1'b1);
    rd_chk(REG_SESSION, 32'h9);
    chk({31'h0, prog_mode_out}, 32'h1);
    rrow(2);
    rrow(63);
    for (int k = 0; k < ROWS; k++) rrow(k);
    $display("test session_and_readback done");
    wr(REG_MASK, 32'h4);
    wrow(4, 4'h7);
    chk_outs();
    chk({31'h0, irq_out}, 32'h1);
    wr(REG_STATUS, 32'h5);
    chk_outs();
    chk({31'h0, irq_out}, 32'h0);
    rd(REG_STATUS, d);
    chk(d & 32'h5, 32'h1);
    wrow(0, 4'h7);
    chk_outs();
    wrow(7, 4'h1);
    chk_outs();
    rd(REG_STATUS, d);
    chk(d & 32'h10, 32'h10);
    wrow(1, 4'h2);
    chk_outs();
    wrow(7, 4'h3);
    chk_outs();
    wrow(63, 4'h0);
    chk_outs();
    rd_chk(REG_CONFIG, exp_cfg());
    $display("test voting_and_parity done");
    d4 = 4'($urandom_range(15));
    wrow(80, d4);
    wr(REG_ARRAY_SEL, 32'd80);
    rd_chk(REG_ARRAY_DATA, {28'h0, cells[80]});
    chk_outs();
    rrow(64);
    rrow(86);
    rrow(120);
    $display("test spare_cells done");
    wrow(63, 4'h7);
    wrow(1, 4'h7);
    chk_outs();
    prg.supply(1'b0);
    prg.supply(1'b1);
    locked = 1'b1;
    rd_chk(REG_SESSION, 32'hb);
    wrow(5, 4'h7);
    chk_outs();
    rd(REG_STATUS, d);
    chk(d & 32'h2, 32'h2);
    rrow(5);
    rrow(1);
    prg.supply(1'b0);
    $display("test lock done");
    report_and_stop();
  end
endmodule
